/* File: include/wkb_pkg.sv */
// package: register map, reset values and bus types of the wake enable bank
//------------------------------------------------------------------------------
// Function
// - wake output asserts for a source only when enable, status and global enable are 1
// - disabled source still records its status but cannot drive the wake output
// - main-power reset, soft reset and bus reset never alter any enable bit
// - group a bits 0..7 select gen_pin_10 through gen_pin_17 in order
// - group b bits 0..7 select gen_pin_20 through gen_pin_27 in order
// - group c maps pins 30..33, 41, 43, 60, 61 onto bits 0..7
// - status bit sets on source event regardless of enables; write 1 clears, 0 no effect
//------------------------------------------------------------------------------
package wkb_pkg;

    //--------------------------------------------------------------------------
    // widths
    //--------------------------------------------------------------------------
    localparam int unsigned GRP_N  = 3;
    localparam int unsigned GRP_W  = 8;
    localparam int unsigned SRC_N  = GRP_N * GRP_W;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned IDX_W  = 6;

    //--------------------------------------------------------------------------
    // register indices, byte address is four times the index
    //--------------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_EN_A   = 6'h0b;
    localparam logic [IDX_W-1:0] IDX_EN_B   = 6'h0c;
    localparam logic [IDX_W-1:0] IDX_EN_C   = 6'h0d;
    localparam logic [IDX_W-1:0] IDX_CTRL   = 6'h20;
    localparam logic [IDX_W-1:0] IDX_STS_A  = 6'h21;
    localparam logic [IDX_W-1:0] IDX_MASK_A = 6'h24;
    localparam logic [IDX_W-1:0] IDX_PEND_A = 6'h27;

    //--------------------------------------------------------------------------
    // field positions and reset values
    //--------------------------------------------------------------------------
    localparam int unsigned      CTRL_GLB_EN_BIT = 0;
    localparam logic [GRP_W-1:0] EN_RST          = 8'h00;
    localparam logic [GRP_W-1:0] STS_RST         = 8'h00;
    localparam logic [GRP_W-1:0] MASK_RST        = 8'h00;
    localparam logic             GLB_EN_RST      = 1'b0;

    //--------------------------------------------------------------------------
    // bus carriers
    //--------------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              pwrite;
        logic [31:0]       pwdata;
        logic [3:0]        pstrb;
    } wkb_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pslverr;
    } wkb_apb_rsp_t;

endpackage

/* File: rtl/wkb_bank.sv */
// module: wake enable bank with apb registers and active-low wake request
`timescale 1ns/1ns
`default_nettype none

module wkb_bank
(
    input  wire logic                  mclk,
    input  wire logic                  arst_n,
    input  wire logic                  clk_en,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire wkb_pkg::wkb_apb_req_t apb_req,
    output logic                       pready,
    output wkb_pkg::wkb_apb_rsp_t      apb_rsp,
    input  wire logic [23:0]           wake_src_in,
    output logic                       wake_request_out_n,
    output logic                       irq
);
    import wkb_pkg::*;

    //--------------------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------------------
    function automatic logic [GRP_N-1:0] grp_hit
    (
        input logic [IDX_W-1:0] i,
        input logic [IDX_W-1:0] base
    );
        logic [GRP_N-1:0] h;
        h = '0;
        for (int k = 0; k < GRP_N; k++)
        begin
            h[k] = (i == (base + IDX_W'(k)));
        end
        return h;
    endfunction

    function automatic logic [SRC_N-1:0] spread
    (
        input logic [GRP_N-1:0] h,
        input logic [GRP_W-1:0] b
    );
        logic [SRC_N-1:0] v;
        v = '0;
        for (int k = 0; k < GRP_N; k++)
        begin
            if (h[k])
            begin
                v[k*GRP_W +: GRP_W] = b;
            end
        end
        return v;
    endfunction

    function automatic logic [GRP_W-1:0] gather
    (
        input logic [GRP_N-1:0] h,
        input logic [SRC_N-1:0] v
    );
        logic [GRP_W-1:0] b;
        b = '0;
        for (int k = 0; k < GRP_N; k++)
        begin
            if (h[k])
            begin
                b = b | v[k*GRP_W +: GRP_W];
            end
        end
        return b;
    endfunction

    //--------------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------------
    logic [SRC_N-1:0] src_s1_r;
    logic [SRC_N-1:0] src_s2_r;
    logic [SRC_N-1:0] wake_en_r;
    logic [SRC_N-1:0] wake_en_nxt;
    logic [SRC_N-1:0] wake_sts_r;
    logic [SRC_N-1:0] wake_sts_nxt;
    logic [SRC_N-1:0] irq_mask_r;
    logic [SRC_N-1:0] irq_mask_nxt;
    logic             global_wake_enable_r;
    logic             global_wake_enable_nxt;
    logic             wake_n_r;
    logic             wake_n_nxt;
    logic             irq_r;
    logic             irq_nxt;
    logic [31:0]      prdata_r;
    logic [31:0]      prdata_nxt;
    logic             pslverr_r;
    logic             pslverr_nxt;

    //--------------------------------------------------------------------------
    // apb decode
    //--------------------------------------------------------------------------
    // a stalled clock enable also stalls the bus in the access phase; a read whose setup cycle has clk_en low returns stale prdata
    wire              setup_ph  = psel & ~penable;
    wire              access_ph = psel & penable;
    wire [IDX_W-1:0]  idx       = apb_req.paddr[IDX_W+1:2];
    wire              aligned   = (apb_req.paddr[1:0] == 2'b00);
    wire [GRP_N-1:0]  hit_en    = aligned ? grp_hit(idx, IDX_EN_A) : '0;
    wire [GRP_N-1:0]  hit_sts   = aligned ? grp_hit(idx, IDX_STS_A) : '0;
    wire [GRP_N-1:0]  hit_mask  = aligned ? grp_hit(idx, IDX_MASK_A) : '0;
    wire [GRP_N-1:0]  hit_pend  = aligned ? grp_hit(idx, IDX_PEND_A) : '0;
    wire              hit_ctrl  = aligned & (idx == IDX_CTRL);
    wire              mapped    = (|hit_en) | (|hit_sts) | (|hit_mask) | (|hit_pend) | hit_ctrl;
    wire              wr_take   = access_ph & clk_en & apb_req.pwrite & apb_req.pstrb[0] & mapped;
    wire [GRP_W-1:0]  wbyte     = apb_req.pwdata[GRP_W-1:0];

    // lane order of wake_src_in follows the bit order of groups a, b, c
    wire [SRC_N-1:0]  en_sel    = wr_take ? spread(hit_en, 8'hff) : '0;
    wire [SRC_N-1:0]  en_dat    = spread(hit_en, wbyte);
    wire [SRC_N-1:0]  mask_sel  = wr_take ? spread(hit_mask, 8'hff) : '0;
    wire [SRC_N-1:0]  mask_dat  = spread(hit_mask, wbyte);
    wire [SRC_N-1:0]  sts_clr   = wr_take ? spread(hit_sts, wbyte) : '0;
    wire              ctrl_wr   = wr_take & hit_ctrl;

    //--------------------------------------------------------------------------
    // wake logic
    //--------------------------------------------------------------------------
    wire [SRC_N-1:0]  pending   = wake_en_r & wake_sts_r;
    wire              any_pend  = |pending;

    assign wake_en_nxt  = (wake_en_r & ~en_sel) | (en_dat & en_sel);
    assign irq_mask_nxt = (irq_mask_r & ~mask_sel) | (mask_dat & mask_sel);
    // set beats clear so an event landing on the clear write survives
    assign wake_sts_nxt = (wake_sts_r & ~sts_clr) | src_s2_r;
    assign global_wake_enable_nxt = ctrl_wr ? wbyte[CTRL_GLB_EN_BIT] : global_wake_enable_r;
    assign wake_n_nxt   = ~(global_wake_enable_r & any_pend);
    assign irq_nxt      = |(wake_sts_r & irq_mask_r);

    //--------------------------------------------------------------------------
    // read path, sampled in the setup cycle
    //--------------------------------------------------------------------------
    wire [GRP_W-1:0]  rd_byte   = gather(hit_en, wake_en_r)
                                | gather(hit_sts, wake_sts_r)
                                | gather(hit_mask, irq_mask_r)
                                | gather(hit_pend, pending)
                                | (hit_ctrl ? {7'h00, global_wake_enable_r} : 8'h00);

    assign prdata_nxt  = setup_ph ? {24'h000000, rd_byte} : prdata_r;
    assign pslverr_nxt = setup_ph ? ~mapped : pslverr_r;

    //--------------------------------------------------------------------------
    // flops: arst_n is the standby power-on reset, the only one that reaches here
    //--------------------------------------------------------------------------
    // no other reset input exists, so enables survive main and bus resets
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wake_en_r            <= {GRP_N{EN_RST}};
            wake_sts_r           <= {GRP_N{STS_RST}};
            irq_mask_r           <= {GRP_N{MASK_RST}};
            global_wake_enable_r <= GLB_EN_RST;
        end
        else if (clk_en)
        begin
            wake_en_r            <= wake_en_nxt;
            wake_sts_r           <= wake_sts_nxt;
            irq_mask_r           <= irq_mask_nxt;
            global_wake_enable_r <= global_wake_enable_nxt;
        end
    end

    // pins are asynchronous to mclk, two flops before any use
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            src_s1_r <= '0;
            src_s2_r <= '0;
        end
        else if (clk_en)
        begin
            src_s1_r <= wake_src_in;
            src_s2_r <= src_s1_r;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wake_n_r  <= 1'b1;
            irq_r     <= 1'b0;
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end
        else if (clk_en)
        begin
            wake_n_r  <= wake_n_nxt;
            irq_r     <= irq_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    assign pready             = clk_en;
    assign apb_rsp.prdata     = prdata_r;
    assign apb_rsp.pslverr    = pslverr_r;
    assign wake_request_out_n = wake_n_r;
    assign irq                = irq_r;

endmodule // wkb_bank

`default_nettype wire

/* File: testbench/wkb_bank_props.sv */
// checker: port-level properties of the wake enable bank
`timescale 1ns/1ns
`default_nettype none
module wkb_bank_props
(
    input wire logic                  mclk,
    input wire logic                  arst_n,
    input wire logic                  clk_en,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire wkb_pkg::wkb_apb_req_t apb_req,
    input wire logic                  pready,
    input wire wkb_pkg::wkb_apb_rsp_t apb_rsp,
    input wire logic [23:0]           wake_src_in,
    input wire logic                  wake_request_out_n,
    input wire logic                  irq
);
    import wkb_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence setup_s;
        psel && !penable && clk_en;
    endsequence
    sequence glb_off_s;
        psel && penable && clk_en && apb_req.pwrite && apb_req.paddr == 8'h80 && apb_req.pstrb[0] && !apb_req.pwdata[0];
    endsequence
    pready_follow_a: assert property (pready == clk_en) else $error("pready not clk_en");
    rdata_upper_a: assert property (apb_rsp.prdata[31:8] == 24'h0) else $error("upper read bits set");
    en_mapped_a: assert property (setup_s ##0 apb_req.paddr inside {8'h2c, 8'h30, 8'h34} |=> !apb_rsp.pslverr)
        else $error("enable register refused");
    misalign_err_a: assert property (setup_s ##0 apb_req.paddr[1:0] != 2'h0 |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("misaligned read not refused");
    wait_hold_a: assert property (psel && penable && !clk_en |=> $stable(apb_rsp)) else $error("read data moved");
    wake_idle_a: assert property ($rose(arst_n) |-> wake_request_out_n [*4]) else $error("wake after reset");
    irq_idle_a: assert property ($rose(arst_n) |-> !irq [*3]) else $error("irq after reset");
    glb_off_a: assert property (glb_off_s |-> ##2 wake_request_out_n) else $error("wake with global off");
endmodule // wkb_bank_props
`default_nettype wire

/* File: testbench/wkb_host_sink.sv */
// model: chipset wake input sampling the active-low request
`timescale 1ns/1ns
`default_nettype none
module wkb_host_sink
(
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic wake_request_out_n,
    output logic      wake_seen
);
    // one flop, as the chipset resamples the pin in its own domain
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            wake_seen <= 1'b0;
        else
            wake_seen <= !wake_request_out_n;
    end
endmodule // wkb_host_sink
`default_nettype wire

/* File: testbench/wkb_bank_tb.sv */
// testbench: wake enable bank over apb
`timescale 1ns/1ns
`default_nettype none
module wkb_bank_tb;
    import wkb_pkg::*;
    logic         mclk, arst_n, clk_en, psel, penable, pready, wake_n, irq, seen, e;
    wkb_apb_req_t apb_req;
    wkb_apb_rsp_t apb_rsp;
    logic [23:0]  src;
    logic [7:0]   q, d, a;
    int           n_tests, n_mismatch, cyc, i;
    integer       seed = 32'h4172b0b8;
    wkb_bank wkb_bank_i (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
        .apb_req(apb_req), .pready(pready), .apb_rsp(apb_rsp), .wake_src_in(src),
        .wake_request_out_n(wake_n), .irq(irq));
    wkb_host_sink wkb_host_sink_i (.mclk(mclk), .arst_n(arst_n), .wake_request_out_n(wake_n), .wake_seen(seen));
    function automatic logic [7:0] en_a(int k);
        return 8'h2c + 8'(4 * (k / 8));
    endfunction
    function automatic logic [7:0] bit_of(int k);
        return 8'h01 << (k % 8);
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        n_tests++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("mismatch %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // stall holds clk_en low in the access phase to exercise waits
    task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] wd, input logic [3:0] s, input int stall);
        int t;
        t = 0;
        psel <= 1'b1;
        apb_req <= '{paddr: ad, pwrite: w, pwdata: {24'h0, wd}, pstrb: s};
        @(posedge mclk);
        penable <= 1'b1;
        clk_en <= (stall == 0);
        @(posedge mclk);
        while (pready !== 1'b1 && t < 50)
        begin
            t++;
            if (t >= stall)
                clk_en <= 1'b1;
            @(posedge mclk);
        end
        if (t >= 50)
        begin
            n_mismatch++;
            $display("mismatch %0t apb wait limit", $time);
        end
        q = apb_rsp.prdata[7:0];
        e = apb_rsp.pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
        apb(1'b1, ad, wd, 4'h1, 0);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] x, input logic xe);
        apb(1'b0, ad, 8'h00, 4'h1, 0);
        chk(q, x);
        chk({7'h0, e}, {7'h0, xe});
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            $display("mismatch %0t cycle limit", $time);
            stop_test();
        end
    end
    initial
    begin
        {arst_n, psel, penable, src, cyc, n_tests, n_mismatch} = '0;
        clk_en = 1'b1;
        apb_req = '0;
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        for (i = 0; i < 24; i += 8) rd(en_a(i), 8'h00, 1'b0);
        rd(8'h00, 8'h00, 1'b1);
        rd(8'h2d, 8'h00, 1'b1);
        $display("test reset done");
        for (i = 0; i < 12; i++)
        begin
            a = en_a(($unsigned($random(seed)) % 3) * 8);
            d = $random(seed);
            wr(a, d);
            apb(1'b1, a, ~d, 4'h0, 0);
            apb(1'b0, a, 8'h00, 4'h1, i % 4);
            chk(q, d);
        end
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rd(a, 8'h00, 1'b0);
        $display("test access done");
        wr(8'h80, 8'h01);
        for (i = 0; i < 24; i++)
        begin
            wr(en_a(i), ~bit_of(i));
            src[i] <= 1'b1;
            repeat (6) @(posedge mclk);
            chk({7'h0, seen}, 8'h00);
            rd(en_a(i) + 8'h58, bit_of(i), 1'b0);
            wr(en_a(i), bit_of(i));
            repeat (3) @(posedge mclk);
            chk({7'h0, seen}, 8'h01);
            rd(en_a(i) + 8'h70, bit_of(i), 1'b0);
            src[i] <= 1'b0;
            wr(en_a(i) + 8'h58, 8'h00);
            repeat (3) @(posedge mclk);
            chk({7'h0, seen}, 8'h01);
            wr(en_a(i) + 8'h58, bit_of(i));
            repeat (3) @(posedge mclk);
            chk({7'h0, seen}, 8'h00);
            wr(en_a(i), 8'h00);
        end
        $display("test lanes done");
        wr(8'h2c, 8'h01);
        src[0] <= 1'b1;
        repeat (6) @(posedge mclk);
        wr(8'h90, 8'h01);
        repeat (2) @(posedge mclk);
        chk({7'h0, irq}, 8'h01);
        wr(8'h80, 8'h00);
        repeat (3) @(posedge mclk);
        chk({7'h0, seen}, 8'h00);
        wr(8'h90, 8'h00);
        repeat (2) @(posedge mclk);
        chk({7'h0, irq}, 8'h00);
        $display("test global done");
        stop_test();
    end
endmodule // wkb_bank_tb
bind wkb_bank wkb_bank_props wkb_bank_props_i (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .apb_req(apb_req), .pready(pready), .apb_rsp(apb_rsp), .wake_src_in(wake_src_in),
    .wake_request_out_n(wake_request_out_n), .irq(irq));
`default_nettype wire
